// File: logic/cifs_pkg.sv
// Package with offsets, field positions, reset values and helpers of the CAN flag block
package cifs_pkg;

  // Register offsets on the plain register port (byte addresses)
  localparam logic [3:0] REG_FLAGS_OFS = 4'h0;  // Interrupt flag and error state register
  localparam logic [3:0] REG_ISTAT_OFS = 4'h4;  // Sticky interrupt status, write one to clear
  localparam logic [3:0] REG_IMASK_OFS = 4'h8;  // Interrupt mask, one enables the source

  // Field positions inside the 16-bit flag register
  localparam int BIT_TX_BUS_OFF  = 13;  // Transmitter bus-off state
  localparam int BIT_TX_PASSIVE  = 12;  // Transmitter error-passive state
  localparam int BIT_RX_PASSIVE  = 11;  // Receiver error-passive state
  localparam int BIT_TX_WARNING  = 10;  // Transmitter error-warning state
  localparam int BIT_RX_WARNING  = 9;   // Receiver error-warning state
  localparam int BIT_ANY_WARNING = 8;   // Either side in error-warning state
  localparam int BIT_INVALID     = 7;   // Invalid message flag
  localparam int BIT_WAKE        = 6;   // Bus wake-up flag
  localparam int BIT_ERR_SUMMARY = 5;   // Error summary flag
  localparam int BIT_FIFO_FULL   = 3;   // Receive FIFO almost full flag
  localparam int BIT_RX_OVERFLOW = 2;   // Receive buffer overflow flag

  // Index of each event inside the packed 5-bit event vectors
  localparam int EV_INVALID = 4;
  localparam int EV_WAKE    = 3;
  localparam int EV_ERR     = 2;
  localparam int EV_FIFO    = 1;
  localparam int EV_OVF     = 0;

  // Index of each error state inside the 6-bit error vector (bit 13 down to 8)
  localparam int ES_TX_BUS_OFF  = 5;
  localparam int ES_TX_PASSIVE  = 4;
  localparam int ES_RX_PASSIVE  = 3;
  localparam int ES_TX_WARNING  = 2;
  localparam int ES_RX_WARNING  = 1;
  localparam int ES_ANY_WARNING = 0;

  // Bits that exist; all others read zero
  localparam logic [15:0] IMPL_MASK = 16'h3fec;
  // Values after reset
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [4:0]  EVT_RST   = 5'h00;
  localparam logic [5:0]  ERR_RST   = 6'h00;

  // Whole state of the top module
  typedef struct packed {
    logic [5:0]  err;    // Registered error states, bit 13 down to 8
    logic [4:0]  flags;  // Flag bits, cleared by writing zero
    logic [4:0]  istat;  // Sticky interrupt status, cleared by writing one
    logic [4:0]  imask;  // Interrupt mask
    logic [15:0] rdata;  // Read data, valid one cycle after the read strobe
    logic        irq;    // Level interrupt
  } cifs_state_t;

  // Place a 5-bit event vector at its flag positions in a 16-bit word
  function automatic logic [15:0] cifs_pack(input logic [4:0] ev);
    logic [15:0] w;
    w = 16'h0000;
    w[BIT_INVALID]     = ev[EV_INVALID];
    w[BIT_WAKE]        = ev[EV_WAKE];
    w[BIT_ERR_SUMMARY] = ev[EV_ERR];
    w[BIT_FIFO_FULL]   = ev[EV_FIFO];
    w[BIT_RX_OVERFLOW] = ev[EV_OVF];
    return w;
  endfunction

  // Pick the flag positions of a 16-bit word into a 5-bit event vector
  function automatic logic [4:0] cifs_unpack(input logic [15:0] w);
    logic [4:0] ev;
    ev = 5'h00;
    ev[EV_INVALID] = w[BIT_INVALID];
    ev[EV_WAKE]    = w[BIT_WAKE];
    ev[EV_ERR]     = w[BIT_ERR_SUMMARY];
    ev[EV_FIFO]    = w[BIT_FIFO_FULL];
    ev[EV_OVF]     = w[BIT_RX_OVERFLOW];
    return ev;
  endfunction

endpackage

// File: logic/cifs_rst_sync.sv
// Reset release synchroniser for the CAN flag block
`timescale 1ns/10ps
module cifs_rst_sync (
  // Clock and raw reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // Synchronised reset, active low
  output logic      rst_n_sync
);

  logic meta_q;  // First stage, read only by the second stage

  // Assert at once, release after two edges so the release is clean
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q     <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      meta_q     <= 1'b1;
      rst_n_sync <= meta_q;
    end
  end

endmodule

// File: logic/cifs_top.sv
// CAN interrupt flag and error state register with interrupt status, mask and output
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/10ps

// Overview of operation
// - Bit 13 shows transmitter bus-off state
// - Bit 12 shows transmitter error-passive state
// - Bit 11 shows receiver error-passive state
// - Bit 10 shows transmitter error-warning state
// - Bit 9 shows receiver error-warning state
// - Bit 8 is OR of both warnings
// - Bit 7 latches invalid message event
// - Bit 6 latches bus wake-up activity
// - Bit 5 latches any new error state
// - Bit 3 latches receive FIFO almost full
// - Bit 2 latches receive buffer overflow
module cifs_top (
  // Clock, reset and clock enable
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Error state levels from the CAN core
  input  wire logic        tx_bus_off_state,
  input  wire logic        tx_passive_state,
  input  wire logic        rx_passive_state,
  input  wire logic        tx_warning_state,
  input  wire logic        rx_warning_state,
  // Event pulses from the CAN core
  input  wire logic        invalid_message_evt,
  input  wire logic        bus_wake_evt,
  input  wire logic        fifo_almost_full_evt,
  input  wire logic        receive_overflow_evt,
  // Interrupt request
  output logic             irq
);

  logic                 rst_n_sync;  // Reset released in step with the clock
  cifs_pkg::cifs_state_t s_q;        // Registered state
  cifs_pkg::cifs_state_t s_d;        // Next state
  logic [5:0]           err_in;      // Error states as seen this cycle
  logic [4:0]           set_ev;      // Flag setting events this cycle
  logic                 wr_flags;    // Write hits the flag register
  logic                 wr_istat;    // Write hits the interrupt status
  logic                 wr_imask;    // Write hits the interrupt mask

  // Limits a user should know:
  // Events seen while clk_en is low are dropped, not queued
  // Error bits lag the core inputs by one cycle
  // The error summary fires on entry to a state, not while it stays
  // Read data is zero unless the read strobe came the cycle before

  // Reset release
  cifs_rst_sync u_rst_sync (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .rst_n_sync (rst_n_sync)
  );

  // Error state vector; the warning summary is formed here
  always_comb begin
    err_in = cifs_pkg::ERR_RST;
    err_in[cifs_pkg::ES_TX_BUS_OFF]  = tx_bus_off_state;
    err_in[cifs_pkg::ES_TX_PASSIVE]  = tx_passive_state;
    err_in[cifs_pkg::ES_RX_PASSIVE]  = rx_passive_state;
    err_in[cifs_pkg::ES_TX_WARNING]  = tx_warning_state;
    err_in[cifs_pkg::ES_RX_WARNING]  = rx_warning_state;
    err_in[cifs_pkg::ES_ANY_WARNING] = tx_warning_state | rx_warning_state;
  end

  // Address decode of writes
  always_comb begin
    wr_flags = 1'b0;
    wr_istat = 1'b0;
    wr_imask = 1'b0;
    // First match wins; an unmapped offset selects nothing
    if (reg_wr && reg_addr == cifs_pkg::REG_FLAGS_OFS) begin
      wr_flags = 1'b1;
    end else if (reg_wr && reg_addr == cifs_pkg::REG_ISTAT_OFS) begin
      wr_istat = 1'b1;
    end else if (reg_wr && reg_addr == cifs_pkg::REG_IMASK_OFS) begin
      wr_imask = 1'b1;
    end
  end

  // Events; the error summary fires on any state bit that rises
  always_comb begin
    set_ev = cifs_pkg::EVT_RST;
    set_ev[cifs_pkg::EV_INVALID] = invalid_message_evt;
    set_ev[cifs_pkg::EV_WAKE]    = bus_wake_evt;
    set_ev[cifs_pkg::EV_ERR]     = |(err_in & ~s_q.err);
    set_ev[cifs_pkg::EV_FIFO]    = fifo_almost_full_evt;
    set_ev[cifs_pkg::EV_OVF]     = receive_overflow_evt;
  end

  // Next state
  always_comb begin
    s_d = s_q;
    // Error states follow the core; the high byte takes no write
    s_d.err = err_in;
    // Flags: a zero written clears, a one keeps; a set in the same cycle wins
    if (wr_flags) begin
      s_d.flags = s_q.flags & cifs_pkg::cifs_unpack(reg_wdata);
    end
    s_d.flags = s_d.flags | set_ev;
    // Interrupt status: write one to clear, again the set wins
    if (wr_istat) begin
      s_d.istat = s_q.istat & ~cifs_pkg::cifs_unpack(reg_wdata);
    end
    s_d.istat = s_d.istat | set_ev;
    // Mask
    if (wr_imask) begin
      s_d.imask = cifs_pkg::cifs_unpack(reg_wdata);
    end
    // Read data stands only in the cycle after the strobe
    s_d.rdata = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == cifs_pkg::REG_FLAGS_OFS) begin
        // Unimplemented bits are masked to zero
        s_d.rdata = ({2'b00, s_q.err, 8'h00} | cifs_pkg::cifs_pack(s_q.flags))
                    & cifs_pkg::IMPL_MASK;
      end else if (reg_addr == cifs_pkg::REG_ISTAT_OFS) begin
        s_d.rdata = cifs_pkg::cifs_pack(s_q.istat);
      end else if (reg_addr == cifs_pkg::REG_IMASK_OFS) begin
        s_d.rdata = cifs_pkg::cifs_pack(s_q.imask);
      end else begin
        // Unmapped address reads zero
        s_d.rdata = 16'h0000;
      end
    end
    // Interrupt from next state so the output is a plain flip-flop
    s_d.irq = |(s_d.istat & s_d.imask);
  end

  // State register; clock enable low freezes everything, events then are lost
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = s_q.rdata;
  assign irq       = s_q.irq;

  // Checks on the behaviour above
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_sync);

  // Bus-off state seen in a read of the flag register
  a_bus_off_read: assert property (
    clk_en ##1 (clk_en && reg_rd && reg_addr == cifs_pkg::REG_FLAGS_OFS)
    |=> reg_rdata[cifs_pkg::BIT_TX_BUS_OFF] == $past(tx_bus_off_state, 2))
    else $error("bus-off bit does not follow the transmitter");

  a_tx_passive_bit: assert property (
    clk_en |=> s_q.err[cifs_pkg::ES_TX_PASSIVE] == $past(tx_passive_state))
    else $error("transmitter passive bit wrong");

  a_rx_passive_bit: assert property (
    clk_en |=> s_q.err[cifs_pkg::ES_RX_PASSIVE] == $past(rx_passive_state))
    else $error("receiver passive bit wrong");

  a_tx_warning_bit: assert property (
    clk_en |=> s_q.err[cifs_pkg::ES_TX_WARNING] == $past(tx_warning_state))
    else $error("transmitter warning bit wrong");

  a_rx_warning_bit: assert property (
    clk_en |=> s_q.err[cifs_pkg::ES_RX_WARNING] == $past(rx_warning_state))
    else $error("receiver warning bit wrong");

  a_any_warning_or: assert property (
    s_q.err[cifs_pkg::ES_ANY_WARNING] ==
      (s_q.err[cifs_pkg::ES_TX_WARNING] | s_q.err[cifs_pkg::ES_RX_WARNING]))
    else $error("warning summary is not the OR of both warnings");

  a_invalid_sets: assert property (
    clk_en && invalid_message_evt |=> s_q.flags[cifs_pkg::EV_INVALID])
    else $error("invalid message flag not set");

  a_wake_sets: assert property (
    clk_en && bus_wake_evt |=> s_q.flags[cifs_pkg::EV_WAKE])
    else $error("wake-up flag not set");

  a_err_summary_sets: assert property (
    clk_en && tx_bus_off_state && !s_q.err[cifs_pkg::ES_TX_BUS_OFF]
    |=> s_q.flags[cifs_pkg::EV_ERR] && s_q.istat[cifs_pkg::EV_ERR])
    else $error("error summary flag not set on new error state");

  a_fifo_sets: assert property (
    clk_en && fifo_almost_full_evt |=> s_q.flags[cifs_pkg::EV_FIFO])
    else $error("fifo almost full flag not set");

  a_overflow_sets: assert property (
    clk_en && receive_overflow_evt |=> s_q.flags[cifs_pkg::EV_OVF])
    else $error("overflow flag not set");

  // Writing zeros with no event clears all flags; writing ones keeps them
  a_zero_clears: assert property (
    clk_en && wr_flags && reg_wdata == 16'h0000 && set_ev == 5'h00
    |=> s_q.flags == 5'h00)
    else $error("writing zero did not clear the flags");

  a_one_keeps: assert property (
    clk_en && wr_flags && reg_wdata == 16'hffff
    |=> (s_q.flags & $past(s_q.flags)) == $past(s_q.flags))
    else $error("writing one changed a flag");

  a_unimpl_zero: assert property (
    (reg_rdata & ~cifs_pkg::IMPL_MASK) == 16'h0000)
    else $error("unimplemented bit read as one");

  // Unmasked pending status raises the interrupt on the next edge
  a_irq_follows: assert property (
    clk_en && |(s_d.istat & s_d.imask) |=> irq)
    else $error("interrupt not raised for unmasked status");

  // Nothing unmasked pending keeps the interrupt low
  a_irq_quiet: assert property (
    clk_en && !(|(s_d.istat & s_d.imask)) |=> !irq)
    else $error("interrupt high with nothing unmasked pending");

  // Every event also lands in the sticky status
  a_status_sets: assert property (
    clk_en && |set_ev |=> (s_q.istat & $past(set_ev)) == $past(set_ev))
    else $error("event did not set its status bit");

  // A one written to the status clears it when no event competes
  a_status_clear: assert property (
    clk_en && wr_istat && set_ev == 5'h00
    |=> s_q.istat == ($past(s_q.istat) & ~cifs_pkg::cifs_unpack($past(reg_wdata))))
    else $error("status bit not cleared by writing one");

  // The mask takes the written flag positions as they are
  a_mask_write: assert property (
    clk_en && wr_imask |=> s_q.imask == cifs_pkg::cifs_unpack($past(reg_wdata)))
    else $error("mask write did not land");

  // Read data stands for one cycle only and is zero otherwise
  a_rdata_idle: assert property (
    clk_en && !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data present without a read");

  // Clock enable low freezes every register
  a_freeze_hold: assert property (
    !clk_en |=> s_q == $past(s_q))
    else $error("state moved while the clock enable was low");

  // A flag never rises without its event; writing ones sets nothing
  a_flags_no_spurious: assert property (
    clk_en && set_ev == 5'h00 |=> (s_q.flags & ~$past(s_q.flags)) == 5'h00)
    else $error("flag rose without an event");

  // Receiver warning entry also raises the error summary
  a_warn_summary: assert property (
    clk_en && rx_warning_state && !s_q.err[cifs_pkg::ES_RX_WARNING]
    |=> s_q.flags[cifs_pkg::EV_ERR])
    else $error("error summary flag not set on warning entry");

  // Receiver passive entry raises the summary in the status as well
  a_passive_summary: assert property (
    clk_en && rx_passive_state && !s_q.err[cifs_pkg::ES_RX_PASSIVE]
    |=> s_q.istat[cifs_pkg::EV_ERR])
    else $error("error summary status not set on passive entry");

  // A read of the flag register shows the latched wake-up flag
  a_wake_read: assert property (
    clk_en && reg_rd && reg_addr == cifs_pkg::REG_FLAGS_OFS
    |=> reg_rdata[cifs_pkg::BIT_WAKE] == $past(s_q.flags[cifs_pkg::EV_WAKE]))
    else $error("wake-up flag wrong in read data");

  // A read of the flag register shows the receiver warning state
  a_rx_warn_read: assert property (
    clk_en && reg_rd && reg_addr == cifs_pkg::REG_FLAGS_OFS
    |=> reg_rdata[cifs_pkg::BIT_RX_WARNING] == $past(s_q.err[cifs_pkg::ES_RX_WARNING]))
    else $error("receiver warning bit wrong in read data");

  // Status and mask reads return the flag positions only
  a_status_read: assert property (
    clk_en && reg_rd && reg_addr == cifs_pkg::REG_ISTAT_OFS
    |=> reg_rdata == cifs_pkg::cifs_pack($past(s_q.istat)))
    else $error("status read data wrong");

  a_mask_read: assert property (
    clk_en && reg_rd && reg_addr == cifs_pkg::REG_IMASK_OFS
    |=> reg_rdata == cifs_pkg::cifs_pack($past(s_q.imask)))
    else $error("mask read data wrong");

  // Offsets outside the map read zero
  a_unmapped_read: assert property (
    clk_en && reg_rd && reg_addr != cifs_pkg::REG_FLAGS_OFS
    && reg_addr != cifs_pkg::REG_ISTAT_OFS && reg_addr != cifs_pkg::REG_IMASK_OFS
    |=> reg_rdata == 16'h0000)
    else $error("unmapped offset did not read zero");

  // Main scenarios
  c_irq_rise: cover property (!irq ##1 irq);
  c_flag_clear: cover property (s_q.flags != 5'h00 ##1 clk_en && wr_flags ##1 s_q.flags == 5'h00);
  c_err_summary: cover property (clk_en && set_ev[cifs_pkg::EV_ERR]);
  c_set_beats_clear: cover property (clk_en && wr_flags && reg_wdata == 16'h0000 && |set_ev);
  c_frozen_event: cover property (!clk_en && |set_ev);

endmodule

// File: test/cifs_core_model.sv
// Behavioural model of the CAN core that feeds error states and events
`timescale 1ns/10ps
module cifs_core_model (
  // Clock
  input  wire logic       sys_clk,
  // Requests from the bench
  input  wire logic [4:0] req_st,
  input  wire logic [3:0] req_ev,
  // Levels and pulses toward the flag block
  output logic      [4:0] st,
  output logic      [3:0] ev
);
  // Outputs move only on the clock, as a synchronous core would; one driver each
  always @(posedge sys_clk) begin
    st <= req_st;
    ev <= req_ev;
  end
endmodule

// File: test/tb_top.sv
// Self-checking bench for the CAN flag and error state block
`timescale 1ns/10ps
module tb_top;
  logic        sys_clk, rstn, clk_en, reg_wr, reg_rd, irq;  // Clock, reset, strobes
  logic [3:0]  reg_addr;                      // Register address
  logic [15:0] reg_wdata, reg_rdata;          // Register data
  logic [4:0]  req_st, st;                    // States: bus-off, passives, warnings
  logic [3:0]  req_ev, ev;                    // Events: invalid, wake, fifo, overflow
  logic [5:0]  m_err_q, m_err_d;              // Reference error states
  logic [4:0]  m_flg_q, m_sts_q, m_msk_q;     // Reference flags, status, mask
  logic [4:0]  m_flg_d, m_sts_d, m_msk_d, m_evt, m_wsel;
  logic [15:0] m_rd_q;                        // Reference read data
  logic        m_irq_q, armed;                // Reference irq, compare enable
  int          n_fail, checks_done, seed, cyc, i;
  logic [31:0] r;                             // Random draw

  cifs_top cifs_top_i (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_bus_off_state(st[4]), .tx_passive_state(st[3]),
    .rx_passive_state(st[2]), .tx_warning_state(st[1]), .rx_warning_state(st[0]),
    .invalid_message_evt(ev[3]), .bus_wake_evt(ev[2]), .fifo_almost_full_evt(ev[1]),
    .receive_overflow_evt(ev[0]), .irq(irq));
  cifs_core_model cifs_core_model_i (.sys_clk(sys_clk), .req_st(req_st), .req_ev(req_ev),
    .st(st), .ev(ev));

  // Clock of 100 ns period
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  // Register word as software should see it
  function automatic logic [15:0] exp_word(input logic [3:0] a);
    case (a)
      cifs_pkg::REG_FLAGS_OFS: return {2'h0, m_err_q, m_flg_q[4:2], 1'b0, m_flg_q[1:0], 2'h0};
      cifs_pkg::REG_ISTAT_OFS: return {8'h00, m_sts_q[4:2], 1'b0, m_sts_q[1:0], 2'h0};
      cifs_pkg::REG_IMASK_OFS: return {8'h00, m_msk_q[4:2], 1'b0, m_msk_q[1:0], 2'h0};
      default: return 16'h0000;  // Unmapped reads zero
    endcase
  endfunction

  // Reference next state; summary flag fires on any newly raised state
  always_comb begin
    m_err_d = {st, st[1] | st[0]};
    m_evt = {ev[3], ev[2], |(m_err_d & ~m_err_q), ev[1], ev[0]};
    m_wsel = {reg_wdata[7:5], reg_wdata[3:2]};
    m_flg_d = ((reg_wr && reg_addr == cifs_pkg::REG_FLAGS_OFS) ? m_flg_q & m_wsel : m_flg_q);
    m_flg_d = m_flg_d | m_evt;
    m_sts_d = ((reg_wr && reg_addr == cifs_pkg::REG_ISTAT_OFS) ? m_sts_q & ~m_wsel : m_sts_q);
    m_sts_d = m_sts_d | m_evt;
    m_msk_d = (reg_wr && reg_addr == cifs_pkg::REG_IMASK_OFS) ? m_wsel : m_msk_q;
  end

  // Reference registers, frozen while the clock enable is low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      {m_err_q, m_flg_q, m_sts_q, m_msk_q, m_rd_q, m_irq_q} <= '0;
    end else if (clk_en) begin
      m_err_q <= m_err_d;
      m_flg_q <= m_flg_d;
      m_sts_q <= m_sts_d;
      m_msk_q <= m_msk_d;
      m_irq_q <= |(m_sts_d & m_msk_d);
      m_rd_q <= reg_rd ? exp_word(reg_addr) : 16'h0000;
    end
  end

  // One comparison, counted
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (exp !== got) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Every settled cycle compared against the reference
  always @(negedge sys_clk) begin
    if (armed) begin
      check("st hi", 16'(m_rd_q[13:11]), 16'(reg_rdata[13:11]));
      check("st lo", 16'(m_rd_q[10:8]), 16'(reg_rdata[10:8]));
      check("fl hi", 16'(m_rd_q[7:6]), 16'(reg_rdata[7:6]));
      check("summary", 16'(m_rd_q[5]), 16'(reg_rdata[5]));
      check("fl lo", 16'(m_rd_q[3:2]), 16'(reg_rdata[3:2]));
      check("unused", 16'h0000, reg_rdata & 16'hc013);
      check("irq", 16'(m_irq_q), 16'(irq));
    end
  end

  // Verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard: the planned run is about 3100 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // One register access; a write when wr is high, a read otherwise
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  // One-cycle event burst from the core
  task automatic pulse(input logic [3:0] e);
    @(posedge sys_clk);
    req_ev <= e;
    @(posedge sys_clk);
    req_ev <= 4'h0;
  endtask

  // Main sequence
  initial begin
    {rstn, clk_en, reg_wr, reg_rd, reg_addr, reg_wdata, req_st, req_ev} = '0;
    {n_fail, checks_done, cyc, armed} = '0;
    seed = 74874;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    clk_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    armed = 1'b1;
    for (i = 0; i < 16; i++) bus(1'b0, 4'(i), 16'h0000);
    for (i = 0; i < 5; i++) begin
      req_st <= 5'h01 << i;  // Each state alone, then a read
      repeat (3) @(posedge sys_clk);
      bus(1'b0, cifs_pkg::REG_FLAGS_OFS, 16'h0000);
    end
    req_st <= 5'h00;
    bus(1'b1, cifs_pkg::REG_FLAGS_OFS, 16'hffff);
    bus(1'b1, cifs_pkg::REG_IMASK_OFS, 16'h00ec);
    pulse(4'hf);
    bus(1'b1, cifs_pkg::REG_FLAGS_OFS, 16'hffff);
    bus(1'b0, cifs_pkg::REG_FLAGS_OFS, 16'h0000);
    bus(1'b1, cifs_pkg::REG_ISTAT_OFS, 16'h00ec);
    bus(1'b1, cifs_pkg::REG_FLAGS_OFS, 16'h0000);
    // Events while frozen are lost
    @(posedge sys_clk);
    clk_en <= 1'b0;
    req_ev <= 4'hf;
    repeat (2) @(posedge sys_clk);
    req_ev <= 4'h0;
    repeat (2) @(posedge sys_clk);
    clk_en <= 1'b1;
    bus(1'b0, cifs_pkg::REG_FLAGS_OFS, 16'h0000);
    // Random traffic with back-to-back strobes and unmapped addresses
    for (i = 0; i < 3000; i++) begin
      @(posedge sys_clk);
      r = $random(seed);
      if (r[3:0] == 4'h0) req_st <= r[8:4];
      req_ev <= r[12:9] & r[16:13] & r[20:17];
      reg_wr <= (r[22:21] == 2'b01);
      reg_rd <= (r[22:21] == 2'b10);
      reg_addr <= r[23] ? r[27:24] : {r[25:24], 2'b00};
      reg_wdata <= 16'($random(seed));
    end
    @(posedge sys_clk);
    {reg_wr, reg_rd, req_ev, req_st} <= '0;
    // Second reset in mid-run with flags set
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b0;
    armed = 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    armed = 1'b1;
    for (i = 0; i < 3; i++) bus(1'b0, 4'(4 * i), 16'h0000);
    report_and_stop();
  end
endmodule
